// ==== hdl/perf_evt_map.vh ====
// event codes, unit masks, register offsets and field layout for the event counter
`ifndef PERF_EVT_MAP_VH
`define PERF_EVT_MAP_VH
`define EV_LOAD_MISS 8'hCB
`define EV_FP_TRANS 8'hCC
`define EV_ASSIST 8'hCD
`define EV_SIMD_RET 8'hCE
`define EV_SAT_RET 8'hCF
`define EV_STALL 8'hD2
`define UM_NONE 8'h00
`define UM_L1_LINE 8'h02
`define UM_L2_MISS 8'h04
`define UM_L2_LINE 8'h08
`define UM_XLATE 8'h10
`define UM_TO_MM 8'h01
`define UM_TO_FP 8'h02
`define UM_REORDER_PORT 8'h01
`define OFS_SEL 12'h000
`define OFS_COUNT 12'h004
`define OFS_SAMPLE 12'h008
`define OFS_STATUS 12'h00C
`define SEL_EVT_LSB 0
`define SEL_UMASK_LSB 8
`define SEL_EN_BIT 16
`define SEL_PRECISE_BIT 17
`define SEL_IDX_LSB 20
`define SEL_IDX_MSB 21
`define SEL_RESET 32'h0000_0000
`define STAT_VALID_BIT 0
`define IDX_COUNTER_ZERO 2'b00
`endif

// ==== hdl/evt_decode.v ====
// event-select decoder: one-cycle count pulse from pipeline conditions
`timescale 1ns/10ps
`default_nettype none
`include "perf_evt_map.vh"
module evt_decode (
  input wire clock, // block clock
  input wire rst_n, // async reset, active low
  input wire [7:0] evt_code, // selected event code
  input wire [7:0] umask, // selected unit mask
  input wire load_retire, // a load retires this cycle
  input wire load_cacheable, // retiring load is cacheable
  input wire load_prefetch, // retiring load is a software prefetch
  input wire load_fault, // retiring load raised a fault
  input wire load_l1_miss_new, // missed first level, new line request
  input wire load_l2_miss, // missed second level
  input wire load_l2_miss_new, // missed second level, new bus request
  input wire load_xlate_miss, // missed data translation buffer
  input wire instr_retire, // an instruction retires this cycle
  input wire instr_is_fp, // it is floating point
  input wire instr_is_mm, // it is legacy packed-integer multimedia
  input wire instr_is_sat, // it does saturating SIMD arithmetic
  input wire empty_state_exec, // empty-multimedia-state op alters stack
  input wire reorder_port_stall, // read-port stall blocks entry this cycle
  output reg hit, // count this cycle
  output reg is_load_evt // selection is a retired-load miss event
);
  reg last_mm_q; // last float/multimedia op was multimedia
  wire load_ok;
  // blocked loads simply never assert retire miss inputs; undercount tolerated
  assign load_ok = load_retire & load_cacheable & ~load_prefetch;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_mm_q <= 1'b0;
    end else if (instr_retire & instr_is_mm) begin
      last_mm_q <= 1'b1;
    end else if (instr_retire & instr_is_fp) begin
      last_mm_q <= 1'b0;
    end
  end
  always @* begin
    hit = 1'b0;
    is_load_evt = (evt_code == `EV_LOAD_MISS);
    case (evt_code)
      `EV_LOAD_MISS: begin
        case (umask)
          `UM_L1_LINE: hit = load_ok & load_l1_miss_new;
          `UM_L2_MISS: hit = load_ok & load_l2_miss;
          `UM_L2_LINE: hit = load_ok & load_l2_miss_new;
          `UM_XLATE: hit = load_ok & load_xlate_miss & ~load_fault;
          default: hit = 1'b0;
        endcase
      end
      `EV_FP_TRANS: begin
        if (umask == `UM_TO_MM) begin
          hit = instr_retire & instr_is_mm & ~last_mm_q;
        end else if (umask == `UM_TO_FP) begin
          hit = instr_retire & instr_is_fp & last_mm_q;
        end
      end
      `EV_ASSIST: hit = (umask == `UM_NONE) & empty_state_exec;
      `EV_SIMD_RET: hit = (umask == `UM_NONE) & instr_retire & instr_is_mm;
      `EV_SAT_RET: hit = (umask == `UM_NONE) & instr_retire & instr_is_sat;
      // level input: every blocked cycle, retries included, is one count
      `EV_STALL: hit = (umask == `UM_REORDER_PORT) & reorder_port_stall;
      default: hit = 1'b0;
    endcase
  end
endmodule // evt_decode
`default_nettype wire

// ==== hdl/perf_event_select_decode.v ====
// event counter top: APB registers, decoder, counter and precise sample
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "perf_evt_map.vh"
module perf_event_select_decode #(
  parameter CNT_W = 32 // counter width
) (
  input wire clock, // block clock, 25 MHz
  input wire rst_n, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready, always high
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error on unmapped address
  input wire load_retire, // a load retires
  input wire load_cacheable, // retiring load is cacheable
  input wire load_prefetch, // retiring load is a prefetch
  input wire load_fault, // retiring load faulted
  input wire load_l1_miss_new, // first-level new line miss
  input wire load_l2_miss, // second-level miss
  input wire load_l2_miss_new, // second-level new bus request
  input wire load_xlate_miss, // translation buffer miss
  input wire instr_retire, // an instruction retires
  input wire [31:0] next_instr_addr, // address of the following instruction
  input wire instr_is_fp, // floating point op
  input wire instr_is_mm, // multimedia op
  input wire instr_is_sat, // saturating SIMD op
  input wire empty_state_exec, // empty-state op alters stack
  input wire reorder_port_stall, // read-port stall cycle
  output reg [CNT_W-1:0] count_q, // current count
  output reg sample_valid_q // precise sample captured
);
  reg [31:0] sel_q;
  reg [31:0] sample_q;
  wire hit;
  wire is_load_evt;
  wire counting;
  wire wr;
  wire rd_ok;

  evt_decode u_dec (
    .clock(clock),
    .rst_n(rst_n),
    .evt_code(sel_q[`SEL_EVT_LSB+7:`SEL_EVT_LSB]),
    .umask(sel_q[`SEL_UMASK_LSB+7:`SEL_UMASK_LSB]),
    .load_retire(load_retire),
    .load_cacheable(load_cacheable),
    .load_prefetch(load_prefetch),
    .load_fault(load_fault),
    .load_l1_miss_new(load_l1_miss_new),
    .load_l2_miss(load_l2_miss),
    .load_l2_miss_new(load_l2_miss_new),
    .load_xlate_miss(load_xlate_miss),
    .instr_retire(instr_retire),
    .instr_is_fp(instr_is_fp),
    .instr_is_mm(instr_is_mm),
    .instr_is_sat(instr_is_sat),
    .empty_state_exec(empty_state_exec),
    .reorder_port_stall(reorder_port_stall),
    .hit(hit),
    .is_load_evt(is_load_evt)
  );

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OFS_SEL) | (a == `OFS_COUNT) | (a == `OFS_SAMPLE) | (a == `OFS_STATUS);
    end
  endfunction

  assign pready = 1'b1;
  assign rd_ok = mapped(paddr);
  assign pslverr = psel & penable & ~rd_ok;
  assign wr = psel & penable & pwrite & rd_ok;
  // load-miss events only meaningful on counter zero; others stay silent
  assign counting = sel_q[`SEL_EN_BIT] & hit &
                    (~is_load_evt | (sel_q[`SEL_IDX_MSB:`SEL_IDX_LSB] == `IDX_COUNTER_ZERO));

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= `SEL_RESET;
      count_q <= {CNT_W{1'b0}};
      sample_q <= 32'h0000_0000;
      sample_valid_q <= 1'b0;
    end else begin
      if (wr && paddr == `OFS_SEL) begin
        sel_q <= pwdata;
      end
      // event in the same cycle as a write still counts on the written value
      if (wr && paddr == `OFS_COUNT) begin
        count_q <= pwdata[CNT_W-1:0] + {{(CNT_W-1){1'b0}}, counting};
      end else if (counting) begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      // sample: address after the causing instruction; set wins over clear
      if (counting && is_load_evt && sel_q[`SEL_PRECISE_BIT]) begin
        sample_q <= next_instr_addr;
        sample_valid_q <= 1'b1;
      end else if (wr && paddr == `OFS_STATUS && pwdata[`STAT_VALID_BIT]) begin
        sample_valid_q <= 1'b0;
      end
    end
  end

  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `OFS_SEL: rdata_d = sel_q;
      `OFS_COUNT: rdata_d[CNT_W-1:0] = count_q;
      `OFS_SAMPLE: rdata_d = sample_q;
      `OFS_STATUS: rdata_d[`STAT_VALID_BIT] = sample_valid_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // taken in the setup cycle so the access phase still needs no wait state;
  // a read shows the registers as they stood one cycle before the access
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule // perf_event_select_decode
`default_nettype wire

// ==== verif/evt_monitor.sv ====
// assertion checker for the event counter, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module evt_monitor #(
  parameter CNT_W = 32 // counter width
) (
  input wire logic clock, // block clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic load_retire, // load retires
  input wire logic load_cacheable, // load is cacheable
  input wire logic load_prefetch, // load is a prefetch
  input wire logic load_fault, // load faulted
  input wire logic load_l2_miss, // second-level miss
  input wire logic load_l2_miss_new, // second-level new request
  input wire logic load_xlate_miss, // translation miss
  input wire logic instr_retire, // instruction retires
  input wire logic instr_is_mm, // multimedia op
  input wire logic instr_is_sat, // saturating op
  input wire logic empty_state_exec, // assist
  input wire logic reorder_port_stall, // read-port stall
  input wire logic [CNT_W-1:0] count_q // counter
);
  reg [31:0] sel_q;
  wire acc = psel && penable && pwrite;
  always @(posedge clock or negedge rst_n)
    if (!rst_n) sel_q <= 32'h0000_0000;
    else if (acc && paddr == 12'h000) sel_q <= pwdata;
  // a count write in the same cycle reloads the count and the event adds to the written value, so leave it out
  wire on = sel_q[16] && !(acc && paddr == 12'h004);
  wire ld = on && sel_q[21:20] == 2'b00 && load_retire && load_cacheable && !load_prefetch;
  wire [15:0] ev = sel_q[15:0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_l2_miss_cnt: assert property (ld && ev == 16'h04CB && load_l2_miss |=>
    count_q == $past(count_q) + 1'b1) else $error("second level miss not counted");
  a_l2_line_cnt: assert property (ld && ev == 16'h08CB && load_l2_miss_new |=>
    count_q == $past(count_q) + 1'b1) else $error("line fetch not counted");
  a_fault_skip: assert property (ld && ev == 16'h10CB && load_xlate_miss && load_fault
    |=> $stable(count_q)) else $error("faulting load counted");
  a_prefetch_skip: assert property (on && ev[7:0] == 8'hCB && load_prefetch
    |=> $stable(count_q)) else $error("prefetch load counted");
  a_assist_cnt: assert property (on && ev == 16'h00CD && empty_state_exec |=>
    count_q == $past(count_q) + 1'b1) else $error("assist not counted");
  a_simd_cnt: assert property (on && ev == 16'h00CE && instr_retire && instr_is_mm |=>
    count_q == $past(count_q) + 1'b1) else $error("simd op not counted");
  a_sat_cnt: assert property (on && ev == 16'h00CF && instr_retire && instr_is_sat |=>
    count_q == $past(count_q) + 1'b1) else $error("saturating op not counted");
  a_stall_each: assert property ((on && ev == 16'h01D2 && reorder_port_stall)[*2] |=>
    count_q == $past(count_q, 2) + 2'd2) else $error("stall cycles miscounted");
  cover property (ld && load_l2_miss);
  cover property ((on && reorder_port_stall)[*3]);
  cover property (on && empty_state_exec);
endmodule // evt_monitor
bind perf_event_select_decode evt_monitor #(.CNT_W(CNT_W)) i_mon (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .load_retire(load_retire),
  .load_cacheable(load_cacheable), .load_prefetch(load_prefetch), .load_fault(load_fault),
  .load_l2_miss(load_l2_miss), .load_l2_miss_new(load_l2_miss_new),
  .load_xlate_miss(load_xlate_miss), .instr_retire(instr_retire),
  .instr_is_mm(instr_is_mm), .instr_is_sat(instr_is_sat),
  .empty_state_exec(empty_state_exec), .reorder_port_stall(reorder_port_stall),
  .count_q(count_q));
`default_nettype wire

// ==== verif/pipe_event_src.sv ====
// pipeline event source model: one-cycle event pulses and next address
`timescale 1ns/10ps
`default_nettype none
module pipe_event_src (
  input wire logic clock, // block clock
  input wire logic go, // emit pattern next cycle
  input wire logic [13:0] pat, // event pattern to emit
  input wire logic [31:0] na, // address following the load
  output logic [13:0] evt, // event lines, one cycle each
  output logic [31:0] next_addr // valid with a retiring load
);
  initial evt = 14'h0000;
  initial next_addr = 32'h0000_0000;
  // address toggles when idle so a capture one idle cycle late never matches
  always @(posedge clock) begin
    evt <= go ? pat : 14'h0000;
    next_addr <= go ? na : ~next_addr;
  end
endmodule // pipe_event_src
`default_nettype wire

// ==== verif/perf_event_select_decode_tb.sv ====
// self-checking bench for the event counter
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module perf_event_select_decode_tb;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, pready, pslverr;
  logic sv, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, nia, count_q;
  logic [31:0] na = 32'hA5A5_0040;
  logic [13:0] pat = 14'h0000, evt;
  int err_total = 0, check_count = 0;
  // {select, pulses, expected count, event pattern}
  logic [47:0] tbl [12] = '{
    48'h0304CB_11_0023,
    48'h0104CB_10_0027,
    48'h0108CB_22_0063,
    48'h0110CB_11_0083,
    48'h0110CB_10_008B,
    48'h0102CB_33_0013,
    48'h0100CD_22_1000,
    48'h0100CE_11_0500,
    48'h0100CF_11_0900,
    48'h0102CC_31_0300,
    48'h0101CC_31_0500,
    48'h0101D2_33_2000};
  always #20 clock = ~clock;
  pipe_event_src i_src (.clock(clock), .go(go), .pat(pat), .na(na), .evt(evt), .next_addr(nia));
  perf_event_select_decode i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .load_retire(evt[0]), .load_cacheable(evt[1]), .load_prefetch(evt[2]),
    .load_fault(evt[3]), .load_l1_miss_new(evt[4]), .load_l2_miss(evt[5]),
    .load_l2_miss_new(evt[6]), .load_xlate_miss(evt[7]), .instr_retire(evt[8]),
    .next_instr_addr(nia), .instr_is_fp(evt[9]), .instr_is_mm(evt[10]),
    .instr_is_sat(evt[11]), .empty_state_exec(evt[12]), .reorder_port_stall(evt[13]),
    .count_q(count_q), .sample_valid_q(sv));
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle limit here: a stuck slave is caught by the watchdog
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int a = 0; a < 16; a += 4) begin
      xfer(1'b0, a[11:0], 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
    end
    foreach (tbl[i]) begin
      xfer(1'b1, 12'h000, {8'h00, tbl[i][47:24]});
      xfer(1'b1, 12'h004, 32'h0000_0000);
      pat <= tbl[i][13:0];
      go <= 1'b1;
      repeat (tbl[i][23:20]) @(posedge clock);
      go <= 1'b0;
      repeat (3) @(posedge clock);
      xfer(1'b0, 12'h004, 32'h0000_0000);
      `CHK(q, {28'h0000000, tbl[i][19:16]})
      `CHK(count_q, {28'h0000000, tbl[i][19:16]})
      $display("test %0d done", i);
    end
    xfer(1'b0, 12'h008, 32'h0000_0000);
    `CHK(q, na)
    `CHK(sv, 1'b1)
    xfer(1'b0, 12'h00C, 32'h0000_0000);
    `CHK(q, 32'h0000_0001)
    xfer(1'b1, 12'h00C, 32'h0000_0001);
    `CHK(sv, 1'b0)
    xfer(1'b0, 12'h00C, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    xfer(1'b0, 12'h010, 32'h0000_0000);
    `CHK({se, q}, 33'h1_0000_0000)
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    conclude();
  end
endmodule // perf_event_select_decode_tb
`default_nettype wire
